/* shared/telemetry_pkg.sv */
// shared constants, types and command codes of the telemetry readback block
package telemetry_pkg;

  // ****************************************
  // timing
  // ****************************************
  localparam int unsigned CLK_PERIOD_NS   = 25;
  localparam int unsigned CONV_TIME_NS    = 8_000_000;
  localparam int unsigned CONV_CYCLES_DEF = CONV_TIME_NS / CLK_PERIOD_NS;

  // ****************************************
  // converter parameter codes
  // ****************************************
  localparam logic [3:0] P_VIN     = 4'h1;
  localparam logic [3:0] P_ICHIP   = 4'h2;
  localparam logic [3:0] P_IIN     = 4'h3;
  localparam logic [3:0] P_DIE     = 4'h4;
  localparam logic [3:0] P_VOUT0   = 4'h5;
  localparam logic [3:0] P_IOUT0   = 4'h6;
  localparam logic [3:0] P_FREQ0   = 4'h7;
  localparam logic [3:0] P_TEMP0   = 4'h8;
  localparam logic [3:0] P_IOUT1   = 4'hA;
  localparam logic [3:0] P_LAST    = 4'hC;
  localparam logic [3:0] CH_STRIDE = 4'h4;
  localparam logic [15:0] SEL_VALID_MASK = 16'h177E;
  localparam logic [15:0] PEAK_MASK      = 16'h177A;

  // ****************************************
  // number formats and reset values
  // ****************************************
  localparam logic [4:0]  L11_BASE_EXP     = 5'h18;
  localparam logic [23:0] TEMP_REF         = 24'h001B00;
  localparam logic [7:0]  PIN_ACCURACY_RST = 8'h32;

  // ****************************************
  // command codes
  // ****************************************
  localparam logic [7:0] CMD_VIN          = 8'h88;
  localparam logic [7:0] CMD_IIN          = 8'h89;
  localparam logic [7:0] CMD_VOUT         = 8'h8B;
  localparam logic [7:0] CMD_IOUT         = 8'h8C;
  localparam logic [7:0] CMD_TEMP_EXT     = 8'h8D;
  localparam logic [7:0] CMD_TEMP_DIE     = 8'h8E;
  localparam logic [7:0] CMD_FREQ         = 8'h95;
  localparam logic [7:0] CMD_POUT         = 8'h96;
  localparam logic [7:0] CMD_PIN          = 8'h97;
  localparam logic [7:0] CMD_PIN_ACC      = 8'hAC;
  localparam logic [7:0] CMD_IOUT_PK      = 8'hD7;
  localparam logic [7:0] CMD_ADC_SELECT   = 8'hD8;
  localparam logic [7:0] CMD_VOUT_PK      = 8'hDD;
  localparam logic [7:0] CMD_VIN_PK       = 8'hDE;
  localparam logic [7:0] CMD_TEMP_EXT_PK  = 8'hDF;
  localparam logic [7:0] CMD_IIN_PK       = 8'hE1;
  localparam logic [7:0] CMD_ICHIP        = 8'hE4;
  localparam logic [7:0] CMD_TEMP_DIE_PK  = 8'hF4;
  localparam logic [7:0] CMD_STORE        = 8'h15;
  localparam logic [7:0] CMD_RESTORE      = 8'h16;
  localparam logic [7:0] CMD_COMPARE      = 8'hF0;

  // ****************************************
  // types
  // ****************************************
  typedef logic signed [23:0] raw_t;

  typedef enum logic [1:0] {
    MODE_RR   = 2'b00,
    MODE_FAST = 2'b01,
    MODE_RSVD = 2'b11
  } mode_e;

  typedef enum logic [1:0] {
    K_L11  = 2'b00,
    K_L16  = 2'b01,
    K_BYTE = 2'b11
  } kind_e;

  typedef struct packed {
    logic       valid;
    logic       read;
    logic       has_data;
    logic       page;
    logic [7:0] code;
    logic [7:0] data;
  } cmd_s;

  typedef struct packed {
    logic        valid;
    logic        ok;
    logic [1:0]  len;
    logic [15:0] data;
  } rsp_s;

  typedef struct packed {
    logic       req;
    logic [3:0] param;
  } conv_s;

  typedef struct packed {
    logic       valid;
    logic [3:0] param;
    raw_t       value;
  } meas_s;

endpackage : telemetry_pkg

/* logic/l11_encoder.sv */
// encoder from signed fixed point to exponent and mantissa words
module l11_encoder
  import telemetry_pkg::*;
(
  // value in, word out
  input  wire raw_t        raw,
  output logic      [15:0] word
);

  raw_t       tmp;
  raw_t       mant;
  logic [3:0] sh;

  // smallest right shift that fits the mantissa in 11 signed bits
  always_comb begin
    tmp = '0;
    sh  = 4'hD;
    for (int i = 13; i >= 0; i--) begin
      tmp = raw >>> i;
      if (tmp[23:10] == {14{tmp[10]}}) begin
        sh = 4'(i);
      end
    end
    mant = raw >>> sh;
    word = {5'(L11_BASE_EXP + 5'(sh)), mant[10:0]};
  end

endmodule : l11_encoder

/* logic/telemetry_readback.sv */
// telemetry readback, peak holds and converter parameter selection
module telemetry_readback
  import telemetry_pkg::*;
#(
  parameter int unsigned CONV_CYCLES = CONV_CYCLES_DEF
) (
  // clock, reset, enable
  input  wire logic                      sys_clk,
  input  wire logic                      rstn,
  input  wire logic                      ce,
  // host command port
  input  wire cmd_s                      cmd,
  output rsp_s                           rsp,
  // converter
  output conv_s                          conv,
  input  wire meas_s                     meas,
  // settings
  input  wire logic        [15:0]        input_filter_resistance,
  input  wire logic        [4:0]         output_voltage_exponent_mode,
  input  wire logic        [1:0][15:0]   current_sense_gain,
  input  wire logic        [1:0][15:0]   current_gain_temp_coefficient,
  input  wire logic        [1:0][15:0]   external_temp_gain,
  input  wire logic        [1:0][15:0]   external_temp_offset,
  input  wire logic                      clear_peak_holds,
  // status
  output logic                           communication_fault,
  output logic             [15:0]        telemetry_fault_enable,
  output logic                           servo_enable,
  output logic                           vin_accuracy_ok,
  output logic                           nvm_store,
  output logic                           nvm_restore,
  output logic                           nvm_compare
);

  // ****************************************
  // functions
  // ****************************************
  function automatic logic sel_ok(input logic [7:0] d);
    return (d[7:4] == 4'h0) && SEL_VALID_MASK[d[3:0]];
  endfunction : sel_ok

  function automatic raw_t fx_mul(input raw_t a, input raw_t b, input int sh);
    logic signed [47:0] p;
    p = a * b;
    return 24'(p >>> sh);
  endfunction : fx_mul

  function automatic raw_t uq(input logic [15:0] v);
    return $signed({8'h00, v});
  endfunction : uq

  function automatic logic [15:0] vout_word(input raw_t r, input logic signed [4:0] e);
    logic [31:0] w;
    int          sh;
    sh = -8 - int'(e);
    w  = {8'h00, r};
    if (sh >= 0) begin
      w = w << sh;
    end else begin
      w = w >> (-sh);
    end
    if (r < 0) begin
      return 16'h0000;
    end
    return (w[31:16] != 16'h0000) ? 16'hFFFF : w[15:0];
  endfunction : vout_word

  // ****************************************
  // state
  // ****************************************
  mode_e       mode_q;
  logic [3:0]  sel_q;
  logic [3:0]  rr_q;
  logic [31:0] cnt_q;
  conv_s       conv_q;
  rsp_s        rsp_q;
  logic        fault_q;
  logic [2:0]  nvm_q;
  raw_t        rd_q    [16];
  raw_t        pk_q    [16];
  logic [15:0] pk_set_q;
  raw_t        pout_q  [2];
  raw_t        pin_q;

  // ****************************************
  // command decode
  // ****************************************
  logic        wr_sel;
  logic        send_byte;
  logic [2:0]  nvm_cmd;
  logic        rd_ok;
  logic        bad_cmd;
  logic        issue;
  logic [3:0]  off;
  logic [3:0]  cur;
  kind_e       rd_kind;
  raw_t        rd_raw;
  logic [15:0] l11_word;

  assign wr_sel    = cmd.valid && !cmd.read && cmd.has_data && (cmd.code == CMD_ADC_SELECT);
  assign send_byte = cmd.valid && !cmd.read && !cmd.has_data;
  assign nvm_cmd   = {send_byte && (cmd.code == CMD_COMPARE),
                      send_byte && (cmd.code == CMD_RESTORE),
                      send_byte && (cmd.code == CMD_STORE)};
  assign off       = cmd.page ? CH_STRIDE : 4'h0;
  assign bad_cmd   = cmd.valid && !(wr_sel || (nvm_cmd != 3'b000) || rd_ok);
  assign issue     = (cnt_q == 32'h0);

  // read lookup by command code and page
  always_comb begin
    rd_ok   = 1'b1;
    rd_kind = K_L11;
    rd_raw  = '0;
    case (cmd.code)
      CMD_VIN:         rd_raw = rd_q[P_VIN];
      CMD_IIN:         rd_raw = rd_q[P_IIN];
      CMD_VOUT: begin
        rd_raw  = rd_q[P_VOUT0 + off];
        rd_kind = K_L16;
      end
      CMD_IOUT:        rd_raw = rd_q[P_IOUT0 + off];
      CMD_TEMP_EXT:    rd_raw = rd_q[P_TEMP0 + off];
      CMD_TEMP_DIE:    rd_raw = rd_q[P_DIE];
      CMD_FREQ:        rd_raw = rd_q[P_FREQ0 + off];
      CMD_POUT:        rd_raw = pout_q[cmd.page];
      CMD_PIN:         rd_raw = pin_q;
      CMD_PIN_ACC:     rd_kind = K_BYTE;
      CMD_IOUT_PK:     rd_raw = pk_q[P_IOUT0 + off];
      CMD_VOUT_PK: begin
        rd_raw  = pk_q[P_VOUT0 + off];
        rd_kind = K_L16;
      end
      CMD_VIN_PK:      rd_raw = pk_q[P_VIN];
      CMD_TEMP_EXT_PK: rd_raw = pk_q[P_TEMP0 + off];
      CMD_IIN_PK:      rd_raw = pk_q[P_IIN];
      CMD_ICHIP:       rd_raw = rd_q[P_ICHIP];
      CMD_TEMP_DIE_PK: rd_raw = pk_q[P_DIE];
      default:         rd_ok = 1'b0;
    endcase
    rd_ok = rd_ok && cmd.read && !cmd.has_data;
  end

  l11_encoder u_enc (
    .raw  (rd_raw),
    .word (l11_word)
  );

  // whole word captured in one edge, so bytes never mix conversions
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      rsp_q <= '0;
    end else if (ce) begin
      rsp_q.valid <= cmd.valid;
      rsp_q.ok    <= cmd.valid && !bad_cmd;
      rsp_q.len   <= !rd_ok ? 2'h0 : (rd_kind == K_BYTE) ? 2'h1 : 2'h2;
      case (rd_kind)
        K_L16:   rsp_q.data <= vout_word(rd_raw, output_voltage_exponent_mode);
        K_BYTE:  rsp_q.data <= {8'h00, PIN_ACCURACY_RST};
        default: rsp_q.data <= l11_word;
      endcase
    end
  end

  assign rsp = rsp_q;

  // ****************************************
  // selection register and mode
  // ****************************************
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      mode_q <= MODE_RR;
      sel_q  <= 4'h0;
    end else if (ce && wr_sel) begin
      sel_q <= cmd.data[3:0];
      if (cmd.data == 8'h00) begin
        mode_q <= MODE_RR;
      end else if (sel_ok(cmd.data)) begin
        mode_q <= MODE_FAST;
      end else begin
        mode_q <= MODE_RSVD;
      end
    end
  end

  always_comb begin
    case (mode_q)
      MODE_RR:   telemetry_fault_enable = 16'hFFFF;
      MODE_FAST: telemetry_fault_enable = 16'h0001 << sel_q;
      MODE_RSVD: telemetry_fault_enable = 16'h0001 << P_DIE;
      default:   telemetry_fault_enable = 16'hFFFF;
    endcase
  end

  assign servo_enable    = (mode_q == MODE_RR);
  assign vin_accuracy_ok = (mode_q == MODE_RR);

  // ****************************************
  // conversion scheduler
  // ****************************************
  always_comb begin
    case (mode_q)
      MODE_RR:   cur = rr_q;
      MODE_FAST: cur = sel_q;
      MODE_RSVD: cur = P_DIE;
      default:   cur = rr_q;
    endcase
  end

  // a new selection is used at the next slot, so its result lands within two slots
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      cnt_q  <= 32'h0;
      rr_q   <= P_VIN;
      conv_q <= '0;
    end else if (ce) begin
      conv_q.req <= issue;
      if (issue) begin
        cnt_q        <= 32'(CONV_CYCLES - 1);
        conv_q.param <= cur;
        if (mode_q == MODE_RR) begin
          rr_q <= (rr_q == P_LAST) ? P_VIN : rr_q + 4'h1;
        end
      end else begin
        cnt_q <= cnt_q - 32'h1;
      end
    end
  end

  assign conv = conv_q;

  // ****************************************
  // faults and memory command strobes
  // ****************************************
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      fault_q <= 1'b0;
      nvm_q   <= 3'b000;
    end else if (ce) begin
      // writing zero returns to round robin and is never a fault
      fault_q <= bad_cmd || (wr_sel && (cmd.data != 8'h00) && !sel_ok(cmd.data))
                 || (issue && mode_q == MODE_RSVD);
      nvm_q   <= nvm_cmd;
    end
  end

  assign communication_fault = fault_q;
  assign nvm_store           = nvm_q[0];
  assign nvm_restore         = nvm_q[1];
  assign nvm_compare         = nvm_q[2];

  // ****************************************
  // measurement processing
  // ****************************************
  logic       ch_m;
  logic [3:0] ch_off;
  raw_t       mval;
  raw_t       ibase;
  raw_t       tcorr;
  raw_t       icorr;
  raw_t       new_val;

  assign ch_m   = (meas.param == P_IOUT1);
  assign ch_off = ch_m ? CH_STRIDE : 4'h0;
  assign mval   = $signed(meas.value);

  always_comb begin
    ibase = fx_mul(mval, uq(current_sense_gain[ch_m]), 8);
    tcorr = fx_mul(rd_q[P_TEMP0 + ch_off], uq(external_temp_gain[ch_m]), 14)
            + $signed(external_temp_offset[ch_m]);
    icorr = ibase + fx_mul(fx_mul(ibase, tcorr - $signed(TEMP_REF), 8),
                           $signed(current_gain_temp_coefficient[ch_m]), 16);
    case (meas.param)
      P_VIN:   new_val = mval + fx_mul(rd_q[P_ICHIP], uq(input_filter_resistance), 8);
      P_IOUT0,
      P_IOUT1: new_val = rd_q[meas.param] + ((icorr - rd_q[meas.param]) >>> 2);
      default: new_val = mval;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      rd_q   <= '{default: '0};
      pout_q <= '{default: '0};
      pin_q  <= '0;
    end else if (ce && meas.valid) begin
      rd_q[meas.param] <= new_val;
      if (meas.param == P_IOUT0 || meas.param == P_IOUT1) begin
        pout_q[ch_m] <= fx_mul(rd_q[P_VOUT0 + ch_off], new_val, 8);
      end
      if (meas.param == P_VIN) begin
        pin_q <= fx_mul(new_val, rd_q[P_IIN], 8);
      end else if (meas.param == P_IIN) begin
        pin_q <= fx_mul(rd_q[P_VIN], new_val, 8);
      end
    end
  end

  // ****************************************
  // peak holds
  // ****************************************
  // a sample in the clearing cycle wins over the clear
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      pk_q     <= '{default: '0};
      pk_set_q <= 16'h0000;
    end else if (ce) begin
      if (clear_peak_holds) begin
        pk_q     <= '{default: '0};
        pk_set_q <= 16'h0000;
      end
      if (meas.valid && PEAK_MASK[meas.param] &&
          (!pk_set_q[meas.param] || clear_peak_holds || new_val > pk_q[meas.param])) begin
        pk_q[meas.param]     <= new_val;
        pk_set_q[meas.param] <= 1'b1;
      end
    end
  end

  // ****************************************
  // assertions
  // ****************************************
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rstn || !ce);

  sequence s_wr_zero;
    wr_sel && (cmd.data == 8'h00);
  endsequence

  sequence s_wr_vout0;
    wr_sel && (cmd.data == 8'h05);
  endsequence

  sequence s_fast_issue;
    issue && (mode_q == MODE_FAST);
  endsequence

  // first input voltage sample after reset or clear-peaks
  sequence s_first_vin;
    meas.valid && meas.param == P_VIN && !pk_set_q[P_VIN];
  endsequence

  a_conv_spacing: assert property (conv.req |=> !conv.req [*8])
    else $error("conversion requests too close");
  a_rsvd_die: assert property ((issue && mode_q == MODE_RSVD) |=> (conv.param == P_DIE && communication_fault))
    else $error("reserved selection did not convert die temperature with fault");
  a_fast_param: assert property (s_fast_issue |=> (conv.req && conv.param == $past(sel_q)))
    else $error("fast mode converted wrong parameter");
  a_rr_wrap: assert property ((issue && mode_q == MODE_RR && rr_q == P_LAST) |=> rr_q == P_VIN)
    else $error("round robin did not wrap");
  a_servo_back: assert property (s_wr_zero |=> (servo_enable && vin_accuracy_ok && telemetry_fault_enable == 16'hFFFF))
    else $error("round robin did not restore faults and servo");
  a_fast_suppress: assert property (s_wr_vout0 |=> (!servo_enable && telemetry_fault_enable == 16'h0020))
    else $error("single selection did not suppress other faults");
  a_peak_first: assert property (s_first_vin |=> pk_q[P_VIN] == $past(new_val))
    else $error("peak after clear did not take next value");
  a_peak_hold: assert property ((meas.valid && meas.param == P_VIN && !clear_peak_holds && pk_set_q[P_VIN]
                                 && new_val <= pk_q[P_VIN]) |=> $stable(pk_q[P_VIN]))
    else $error("peak dropped to a smaller value");
  a_rsp_timing: assert property (cmd.valid |=> (rsp.valid && rsp.ok == !$past(bad_cmd)))
    else $error("response missing one cycle after command");
  a_nvm_store: assert property ((send_byte && cmd.code == CMD_STORE) |=> (nvm_store && !nvm_restore && !nvm_compare))
    else $error("store command strobe wrong");

endmodule : telemetry_readback

/* tb/conv_model.sv */
// converter model answering conversion requests from a value table
module conv_model
  import telemetry_pkg::*;
(
  // clock and reset
  input  wire logic         sys_clk,
  input  wire logic         rstn,
  // answer timing and values
  input  wire logic         slow,
  input  wire raw_t  [15:0] vals,
  // converter handshake
  input  wire conv_s        conv,
  output meas_s             meas
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [3:0] cnt_q;
  logic [3:0] prm_q;
  // ****************************************
  // answer after one or nine cycles
  // ****************************************
  always @(posedge sys_clk) begin
    if (!rstn) begin
      cnt_q <= 4'h0;
      meas  <= '0;
    end else if (conv.req) begin
      cnt_q      <= slow ? 4'h9 : 4'h1;
      prm_q      <= conv.param;
      meas.valid <= 1'b0;
    end else if (cnt_q == 4'h1) begin
      cnt_q <= 4'h0;
      meas  <= '{1'b1, prm_q, vals[prm_q]};
    end else begin
      // idle value keeps changing so nothing stale looks valid
      cnt_q <= (cnt_q == 4'h0) ? 4'h0 : cnt_q - 4'h1;
      meas  <= '{1'b0, ~meas.param, ~meas.value};
    end
  end
endmodule : conv_model

/* tb/telemetry_readback_adc_select_bench.sv */
// self-checking bench of the telemetry readback block
module telemetry_readback_adc_select_bench
  import telemetry_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int CONV = 16;
  logic sys_clk, rstn, slow, clr, cf, sv, va, ns, nr, nc;
  cmd_s cmd;
  rsp_s rsp, r;
  conv_s conv;
  meas_s meas;
  raw_t [15:0] vals;
  logic [15:0] tfe;
  logic [2:0] nv;
  logic [3:0] rr[$];
  logic [7:0] codes[$];
  int error_cnt = 0, checks = 0, cf_cnt = 0, k, c0;
  telemetry_readback #(.CONV_CYCLES(CONV)) dut (
    .sys_clk(sys_clk), .rstn(rstn), .ce(1'b1), .cmd(cmd), .rsp(rsp), .conv(conv), .meas(meas),
    .input_filter_resistance(16'h0100), .output_voltage_exponent_mode(5'h18),
    .current_sense_gain({2{16'h0100}}), .current_gain_temp_coefficient('0),
    .external_temp_gain({2{16'h4000}}), .external_temp_offset('0), .clear_peak_holds(clr),
    .communication_fault(cf), .telemetry_fault_enable(tfe), .servo_enable(sv),
    .vin_accuracy_ok(va), .nvm_store(ns), .nvm_restore(nr), .nvm_compare(nc));
  conv_model far (.sys_clk(sys_clk), .rstn(rstn), .slow(slow), .vals(vals), .conv(conv), .meas(meas));
  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) begin
    if (conv.req && rr.size() < 12) rr.push_back(conv.param);
    if (cf) cf_cnt++;
  end
  // ****************************************
  // helpers
  // ****************************************
  function automatic logic [15:0] l11(input logic signed [23:0] v);
    int s;
    s = 0;
    while (v > 1023 || v < -1024) begin
      v = v >>> 1;
      s++;
    end
    return {5'(s - 8), v[10:0]};
  endfunction : l11
  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : end_sim
  task automatic check(input string w, input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", w, exp, seen);
    end
  endtask : check
  task automatic xfer(input logic rd, input logic hd, input logic pg, input logic [7:0] code, input logic [7:0] d);
    @(posedge sys_clk) #1;
    cmd = '{1'b1, rd, hd, pg, code, d};
    @(posedge sys_clk) #1;
    cmd = '0;
    r = rsp;
    c0 = cf;
    nv = {ns, nr, nc};
  endtask : xfer
  task automatic rd(input logic pg, input logic [7:0] code, input logic [15:0] exp, input logic [1:0] n);
    xfer(1'b1, 1'b0, pg, code, 8'h00);
    check($sformatf("ok %h", code), {15'h0, r.ok & r.valid}, 16'h0001);
    check($sformatf("len %h", code), {14'h0, r.len}, {14'h0, n});
    check($sformatf("data %h", code), r.data, exp);
  endtask : rd
  task automatic wait_req;
    k = 0;
    do begin
      @(posedge sys_clk) #1;
      k++;
    end while (!conv.req && k < 4 * CONV);
    if (!conv.req) begin
      error_cnt++;
      $display("mismatch conversion request expected pulse seen none");
      end_sim();
    end
  endtask : wait_req
  // ****************************************
  // tests
  // ****************************************
  initial begin
    rstn = 1'b0;
    cmd  = '0;
    slow = 1'b0;
    clr  = 1'b0;
    vals = '0;
    vals[1] = 24'h000C00;
    vals[2] = 24'h000040;
    vals[3] = 24'h000200;
    vals[4] = 24'h002D00;
    vals[5] = 24'h000100;
    vals[6] = 24'h000400;
    vals[7] = 24'h01F400;
    vals[8] = 24'h001E00;
    vals[9] = 24'h000200;
    repeat (3) @(posedge sys_clk);
    #1 rstn = 1'b1;
    check("servo", sv, 16'h1);
    check("fault enable", tfe, 16'hFFFF);
    repeat (26 * CONV) @(posedge sys_clk);
    for (int i = 0; i < 12; i++) check("order", 16'(rr[i]), 16'(i + 1));
    rd(1'b0, CMD_IOUT, l11(24'h0001C0), 2'd2);
    rd(1'b0, CMD_POUT, l11(24'h0001C0), 2'd2);
    rd(1'b0, CMD_IOUT_PK, l11(24'h0001C0), 2'd2);
    rd(1'b0, CMD_PIN, l11(24'h001880), 2'd2);
    rd(1'b0, CMD_IIN_PK, l11(24'h000200), 2'd2);
    rd(1'b0, CMD_TEMP_DIE_PK, l11(24'h002D00), 2'd2);
    rd(1'b0, CMD_TEMP_EXT_PK, l11(24'h001E00), 2'd2);
    rd(1'b0, CMD_VIN, l11(24'h000C40), 2'd2);
    rd(1'b0, CMD_ICHIP, l11(24'h000040), 2'd2);
    rd(1'b0, CMD_IIN, l11(24'h000200), 2'd2);
    rd(1'b0, CMD_TEMP_DIE, l11(24'h002D00), 2'd2);
    rd(1'b0, CMD_TEMP_EXT, l11(24'h001E00), 2'd2);
    rd(1'b0, CMD_FREQ, l11(24'h01F400), 2'd2);
    rd(1'b0, CMD_VOUT, 16'h0100, 2'd2);
    rd(1'b1, CMD_VOUT, 16'h0200, 2'd2);
    rd(1'b0, CMD_VOUT_PK, 16'h0100, 2'd2);
    rd(1'b0, CMD_PIN_ACC, {8'h00, PIN_ACCURACY_RST}, 2'd1);
    $display("test readings done");
    vals[1] = 24'h000800;
    repeat (14 * CONV) @(posedge sys_clk);
    rd(1'b0, CMD_VIN, l11(24'h000840), 2'd2);
    rd(1'b0, CMD_VIN_PK, l11(24'h000C40), 2'd2);
    @(posedge sys_clk) #1 clr = 1'b1;
    @(posedge sys_clk) #1 clr = 1'b0;
    repeat (14 * CONV) @(posedge sys_clk);
    rd(1'b0, CMD_VIN_PK, l11(24'h000840), 2'd2);
    $display("test peaks done");
    slow = 1'b1;
    codes = '{8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h08, 8'h09, 8'h0A, 8'h0C};
    foreach (codes[i]) begin
      xfer(1'b0, 1'b1, 1'b0, CMD_ADC_SELECT, codes[i]);
      check("select ok", {15'h0, r.ok}, 16'h1);
      check("servo", {15'h0, sv}, 16'h0);
      check("vin accuracy", {15'h0, va}, 16'h0);
      check("fault enable", tfe, 16'h0001 << codes[i]);
      repeat (3 * CONV) @(posedge sys_clk);
      wait_req();
      check("fast param", 16'(conv.param), 16'(codes[i]));
      wait_req();
      check("fast period", 16'(k), 16'(CONV));
    end
    codes = '{8'h07, 8'h0B, 8'h0D, 8'h0E, 8'h0F};
    foreach (codes[i]) begin
      xfer(1'b0, 1'b1, 1'b0, CMD_ADC_SELECT, codes[i]);
      repeat (3 * CONV) @(posedge sys_clk);
      wait_req();
      check("reserved param", 16'(conv.param), 16'(P_DIE));
      c0 = cf_cnt;
      repeat (2 * CONV + 2) @(posedge sys_clk);
      check("fault repeats", 16'(cf_cnt - c0 >= 2), 16'h1);
    end
    xfer(1'b0, 1'b1, 1'b0, CMD_ADC_SELECT, 8'h00);
    xfer(1'b0, 1'b1, 1'b0, CMD_ADC_SELECT, 8'h00);
    check("zero select fault", 16'(c0), 16'h0);
    check("servo back", {15'h0, sv}, 16'h1);
    check("vin accuracy back", {15'h0, va}, 16'h1);
    check("faults back", tfe, 16'hFFFF);
    $display("test selection done");
    xfer(1'b1, 1'b0, 1'b0, CMD_ADC_SELECT, 8'h00);
    check("select read", {14'h0, r.ok, c0[0]}, 16'h1);
    xfer(1'b0, 1'b0, 1'b0, CMD_ADC_SELECT, 8'h00);
    check("select no data", {14'h0, r.ok, c0[0]}, 16'h1);
    xfer(1'b0, 1'b1, 1'b0, CMD_STORE, 8'h11);
    check("store with data", {13'h0, r.ok, nv[2], c0[0]}, 16'h1);
    xfer(1'b0, 1'b1, 1'b0, CMD_VIN, 8'h01);
    check("write read only", {14'h0, r.ok, c0[0]}, 16'h1);
    codes = '{CMD_STORE, CMD_RESTORE, CMD_COMPARE};
    foreach (codes[i]) begin
      xfer(1'b0, 1'b0, 1'b0, codes[i], 8'h00);
      check("memory command", {10'h0, r.ok, r.len, nv}, {10'h0, 1'b1, 2'd0, 3'(3'b100 >> i)});
    end
    $display("test commands done");
    end_sim();
  end
endmodule : telemetry_readback_adc_select_bench
